// [verilog/ctc_pkg.sv]
// Shared constants and types for the cassette transfer control block
package ctc_pkg;
   // Register indices and byte addresses (byte address is four times index)
   localparam logic [7:0] CTC_IDX_STAT     = 8'h0D;
   localparam logic [7:0] CTC_IDX_CMD      = 8'h0E;
   localparam logic [9:0] CTC_ADDR_STAT    = {CTC_IDX_STAT, 2'b00};
   localparam logic [9:0] CTC_ADDR_CMD     = {CTC_IDX_CMD, 2'b00};
   localparam logic [9:0] CTC_ADDR_IRQ_ST  = 10'h040;
   localparam logic [9:0] CTC_ADDR_IRQ_EN  = 10'h044;
   localparam logic [9:0] CTC_ADDR_IRQ_CLR = 10'h048;
   // Command word fields
   localparam int         CTC_CB_TO        = 0;
   localparam int         CTC_CB_FROM      = 1;
   localparam int         CTC_CB_CMP       = 2;
   localparam int         CTC_CB_DIFF      = 3;
   localparam int         CTC_CB_ERR_LO    = 12;
   // Error vector positions, bit 12 upward
   localparam int         CTC_E_PGM        = 0;
   localparam int         CTC_E_WP         = 1;
   localparam int         CTC_E_CAP        = 2;
   localparam int         CTC_E_NOPRG      = 3;
   // Status word fields
   localparam int         CTC_SB_WP        = 2;
   localparam int         CTC_SB_TYPE_LO   = 4;
   // Cassette type codes
   localparam logic [3:0] CTC_CT_NONE      = 4'h0;
   localparam logic [3:0] CTC_CT_EE4K      = 4'h1;
   localparam logic [3:0] CTC_CT_EE8K      = 4'h2;
   localparam logic [3:0] CTC_CT_FL16K     = 4'h3;
   localparam logic [3:0] CTC_CT_EPROM     = 4'h4;
   // Word counts; program length fits 15 bits
   localparam int          CTC_LW          = 15;
   localparam logic [14:0] CTC_CAP_EE4K    = 15'h1000;
   localparam logic [14:0] CTC_CAP_EE8K    = 15'h2000;
   localparam logic [14:0] CTC_CAP_FL16K   = 15'h4000;
   // Interrupt events
   localparam int         CTC_IRQ_N        = 2;
   localparam int         CTC_EV_DONE      = 0;
   localparam int         CTC_EV_REFUSE    = 1;
   localparam logic [31:0] CTC_RST_WORD    = 32'h0000_0000;

   typedef enum logic [1:0] {OP_TO, OP_FROM, OP_CMP} ctc_op_t;
   typedef enum logic [3:0] {
      S_IDLE, S_CHECK, S_UM_RD, S_UM_LAT, S_CAS_REQ, S_CAS_REL, S_UM_WR, S_NEXT, S_FINISH
   } ctc_state_t;
endpackage

// [verilog/ctc_sync.sv]
// Two-stage synchroniser for cassette pin inputs
`timescale 1ns/10ps
module ctc_sync #(
   parameter int W = 1
) (
   // Clock and control
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         ce,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } ctc_sync_st_t;

   ctc_sync_st_t st_r;
   ctc_sync_st_t st_nxt;

   // First stage feeds only the second stage
   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.s2;
endmodule

// [verilog/ctc_irq.sv]
// Sticky interrupt status with enable and write-one-to-clear
`timescale 1ns/10ps
module ctc_irq #(
   parameter int N = 2
) (
   // Clock and control
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         ce,
   // Events and register writes
   input  wire logic [N-1:0] ev,
   input  wire logic         en_we,
   input  wire logic         clr_we,
   input  wire logic [N-1:0] wdata,
   // State
   output logic      [N-1:0] status,
   output logic      [N-1:0] enable,
   output logic              irq
);
   typedef struct packed {
      logic [N-1:0] stat;
      logic [N-1:0] en;
   } ctc_irq_st_t;

   ctc_irq_st_t st_r;
   ctc_irq_st_t st_nxt;

   // New event beats a clear in the same cycle
   always_comb begin
      st_nxt = st_r;
      if (clr_we) begin
         st_nxt.stat = st_r.stat & ~wdata;
      end
      st_nxt.stat = st_nxt.stat | ev;
      if (en_we) begin
         st_nxt.en = wdata;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign status = st_r.stat;
   assign enable = st_r.en;
   assign irq    = |(st_r.stat & st_r.en);
endmodule

// [verilog/ctc_top.sv]
// Cassette transfer control: APB registers, command sequencer, cassette handshake
//
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
module ctc_top
   import ctc_pkg::*;
#(
   parameter int          DW          = 16,
   parameter int          AW          = 14,
   parameter int          PAW         = 12,
   parameter logic [14:0] UM_WORDS    = 15'h4000,
   parameter logic [14:0] EPROM_WORDS = 15'h4000
) (
   // Clock, reset, enable
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ce,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [PAW-1:0]    paddr,
   input  wire logic [31:0]       pwdata,
   output logic                   pready,
   output logic      [31:0]       prdata,
   output logic                   pslverr,
   // Interrupt
   output logic                   irq,
   // Controller state, same clock
   input  wire logic              prog_mode,
   input  wire logic [CTC_LW-1:0] prog_len,
   // Internal program memory, one cycle read latency
   output logic      [AW-1:0]     um_addr,
   output logic      [DW-1:0]     um_wdata,
   output logic                   um_we,
   input  wire logic [DW-1:0]     um_rdata,
   // Cassette pins
   input  wire logic [3:0]        cas_type,
   input  wire logic              cas_wp_sw,
   input  wire logic [CTC_LW-1:0] cas_len,
   input  wire logic              cas_ack,
   input  wire logic [DW-1:0]     cas_rdata,
   output logic      [AW-1:0]     cas_addr,
   output logic      [DW-1:0]     cas_wdata,
   output logic                   cas_we,
   output logic                   cas_re,
   // Activity
   output logic                   busy
);
   localparam int SW = 4 + 1 + CTC_LW + 1 + DW;

   typedef struct packed {
      ctc_state_t        state;
      ctc_op_t           op;
      logic [2:0]        cmd;
      logic              diff;
      logic [3:0]        err;
      logic [CTC_LW-1:0] idx;
      logic [CTC_LW-1:0] len;
      logic [DW-1:0]     data;
      logic              um_we;
      logic              cas_we;
      logic              cas_re;
      logic [31:0]       prdata;
      logic              pslverr;
   } ctc_st_t;

   ctc_st_t            st_r;
   ctc_st_t            st_nxt;
   logic [SW-1:0]      sync_q;
   logic [3:0]         type_s;
   logic               wp_sw_s;
   logic [CTC_LW-1:0]  cas_len_s;
   logic               ack_s;
   logic [DW-1:0]      rdata_s;
   logic               wp_flag;
   logic               setup;
   logic               wr_acc;
   logic [2:0]         cmd_set;
   logic [2:0]         cmd_clr;
   logic [3:0]         err_chk;
   logic [31:0]        rd_mux;
   logic               mapped;
   logic [CTC_LW-1:0]  idx_inc;
   logic [1:0]         irq_st;
   logic [1:0]         irq_en;
   logic [1:0]         irq_ev;
   logic [15:0]        stat_word;
   logic [15:0]        cmd_word;

   // Destination capacity of a cassette type
   function automatic logic [CTC_LW-1:0] cap_of(input logic [3:0] t);
      case (t)
         CTC_CT_EE4K:  cap_of = CTC_CAP_EE4K;
         CTC_CT_EE8K:  cap_of = CTC_CAP_EE8K;
         CTC_CT_FL16K: cap_of = CTC_CAP_FL16K;
         CTC_CT_EPROM: cap_of = EPROM_WORDS;
         default:      cap_of = '0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Cassette pins come from outside the clock domain
   ctc_sync #(
      .W (SW)
   ) u_sync (
      .clk (clk),
      .rst (rst),
      .ce  (ce),
      .d   ({cas_type, cas_wp_sw, cas_len, cas_ack, cas_rdata}),
      .q   (sync_q)
   );

   // Length and read data are quasi-static whenever they are sampled
   assign {type_s, wp_sw_s, cas_len_s, ack_s, rdata_s} = sync_q;

   // EPROM is protected whatever the switch says
   assign wp_flag = (type_s == CTC_CT_EPROM) ||
                    (wp_sw_s && (type_s == CTC_CT_EE4K || type_s == CTC_CT_EE8K ||
                                 type_s == CTC_CT_FL16K));

   ////////////////////////////////////////////////////////////////////////////
   // APB decode; zero wait states, read data latched in setup
   assign setup   = psel && !penable;
   assign pready  = psel && penable && ce;
   assign wr_acc  = pready && pwrite;
   assign idx_inc = CTC_LW'(st_r.idx + 1'b1);

   // Register images
   always_comb begin
      stat_word                                = '0;
      stat_word[CTC_SB_TYPE_LO +: 4]           = type_s;
      stat_word[CTC_SB_WP]                     = wp_flag;
      cmd_word                                 = '0;
      cmd_word[2:0]                            = st_r.cmd;
      cmd_word[CTC_CB_DIFF]                    = st_r.diff;
      cmd_word[CTC_CB_ERR_LO +: 4]             = st_r.err;
   end

   // Read mux; unmapped addresses answer with an error
   always_comb begin
      rd_mux = CTC_RST_WORD;
      mapped = 1'b1;
      if (paddr == PAW'(CTC_ADDR_STAT)) begin
         rd_mux = {16'h0000, stat_word};
      end else if (paddr == PAW'(CTC_ADDR_CMD)) begin
         rd_mux = {16'h0000, cmd_word};
      end else if (paddr == PAW'(CTC_ADDR_IRQ_ST)) begin
         rd_mux = {30'h0000_0000, irq_st};
      end else if (paddr == PAW'(CTC_ADDR_IRQ_EN)) begin
         rd_mux = {30'h0000_0000, irq_en};
      end else if (paddr != PAW'(CTC_ADDR_IRQ_CLR)) begin
         mapped = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer and register file next state
   always_comb begin
      st_nxt  = st_r;
      cmd_set = '0;
      cmd_clr = '0;
      err_chk = '0;
      // Command bits are set-only from software
      if (wr_acc && paddr == PAW'(CTC_ADDR_CMD)) begin
         cmd_set = pwdata[2:0];
      end
      if (setup) begin
         st_nxt.prdata  = rd_mux;
         st_nxt.pslverr = !mapped;
      end
      case (st_r.state)
         S_IDLE: begin
            // One command at a time, lowest bit first
            if (|st_r.cmd) begin
               if (st_r.cmd[CTC_CB_TO]) begin
                  st_nxt.op = OP_TO;
               end else if (st_r.cmd[CTC_CB_FROM]) begin
                  st_nxt.op = OP_FROM;
               end else begin
                  st_nxt.op = OP_CMP;
               end
               st_nxt.diff  = 1'b0;
               st_nxt.err   = '0;
               st_nxt.state = S_CHECK;
            end
         end
         S_CHECK: begin
            // Refusal checks, editing mode first
            if (st_r.op != OP_CMP && prog_mode) begin
               err_chk[CTC_E_PGM] = 1'b1;
            end else if (st_r.op == OP_TO && wp_flag) begin
               err_chk[CTC_E_WP] = 1'b1;
            end else if (st_r.op == OP_TO && prog_len > cap_of(type_s)) begin
               err_chk[CTC_E_CAP] = 1'b1;
            end else if (st_r.op == OP_FROM && cas_len_s == '0) begin
               err_chk[CTC_E_NOPRG] = 1'b1;
            end else if (st_r.op == OP_FROM && cas_len_s > UM_WORDS) begin
               err_chk[CTC_E_CAP] = 1'b1;
            end
            st_nxt.idx = '0;
            if (|err_chk) begin
               st_nxt.err   = err_chk;
               st_nxt.state = S_FINISH;
            end else if (st_r.op == OP_CMP && (type_s == CTC_CT_NONE ||
                         cas_len_s == '0 || cas_len_s != prog_len)) begin
               // Compare impossible or lengths differ
               st_nxt.diff  = 1'b1;
               st_nxt.state = S_FINISH;
            end else begin
               st_nxt.len = (st_r.op == OP_TO) ? prog_len : cas_len_s;
               if (st_nxt.len == '0) begin
                  st_nxt.state = S_FINISH;
               end else if (st_r.op == OP_FROM) begin
                  st_nxt.state = S_CAS_REQ;
               end else begin
                  st_nxt.state = S_UM_RD;
               end
            end
         end
         S_UM_RD: begin
            // Memory samples the address this cycle
            st_nxt.state = S_UM_LAT;
         end
         S_UM_LAT: begin
            st_nxt.data  = um_rdata;
            st_nxt.state = S_CAS_REQ;
         end
         S_CAS_REQ: begin
            // Four-phase handshake survives the synchroniser delay
            if (ack_s) begin
               if (st_r.op == OP_FROM) begin
                  st_nxt.data = rdata_s;
               end else if (st_r.op == OP_CMP && rdata_s != st_r.data) begin
                  st_nxt.diff = 1'b1;
               end
               st_nxt.state = S_CAS_REL;
            end
         end
         S_CAS_REL: begin
            if (!ack_s) begin
               st_nxt.state = (st_r.op == OP_FROM) ? S_UM_WR : S_NEXT;
            end
         end
         S_UM_WR: begin
            st_nxt.state = S_NEXT;
         end
         S_NEXT: begin
            st_nxt.idx = idx_inc;
            if (idx_inc == st_r.len) begin
               st_nxt.state = S_FINISH;
            end else if (st_r.op == OP_FROM) begin
               st_nxt.state = S_CAS_REQ;
            end else begin
               st_nxt.state = S_UM_RD;
            end
         end
         S_FINISH: begin
            cmd_clr[st_r.op] = 1'b1;
            st_nxt.state     = S_IDLE;
         end
         default: begin
            st_nxt.state = S_IDLE;
         end
      endcase
      // A new request beats the completion clear
      st_nxt.cmd    = (st_r.cmd & ~cmd_clr) | cmd_set;
      st_nxt.um_we  = (st_nxt.state == S_UM_WR);
      st_nxt.cas_we = (st_nxt.state == S_CAS_REQ) && (st_nxt.op == OP_TO);
      st_nxt.cas_re = (st_nxt.state == S_CAS_REQ) && (st_nxt.op != OP_TO);
   end

   // State register, frozen while ce is low
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r       <= '0;
         st_r.state <= S_IDLE;
         st_r.op    <= OP_TO;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts: completion and refusal
   assign irq_ev[CTC_EV_DONE]   = ce && (st_r.state == S_FINISH);
   assign irq_ev[CTC_EV_REFUSE] = ce && (st_r.state == S_CHECK) && (|err_chk);

   ctc_irq #(
      .N (CTC_IRQ_N)
   ) u_irq (
      .clk    (clk),
      .rst    (rst),
      .ce     (ce),
      .ev     (irq_ev),
      .en_we  (wr_acc && paddr == PAW'(CTC_ADDR_IRQ_EN)),
      .clr_we (wr_acc && paddr == PAW'(CTC_ADDR_IRQ_CLR)),
      .wdata  (pwdata[1:0]),
      .status (irq_st),
      .enable (irq_en),
      .irq    (irq)
   );

   // Outputs straight from flops, except pslverr gated by pready and busy decoded from state
   assign prdata    = st_r.prdata;
   assign pslverr   = st_r.pslverr && pready;
   assign um_addr   = st_r.idx[AW-1:0];
   assign cas_addr  = st_r.idx[AW-1:0];
   assign um_wdata  = st_r.data;
   assign cas_wdata = st_r.data;
   assign um_we     = st_r.um_we;
   assign cas_we    = st_r.cas_we;
   assign cas_re    = st_r.cas_re;
   assign busy      = (st_r.state != S_IDLE);

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst || !ce);

   type_code_a: assert property (setup && paddr == PAW'(CTC_ADDR_STAT) |=>
      prdata[7:4] == $past(type_s)) else $error("cassette type code wrong");
   to_clear_a: assert property (st_r.state == S_FINISH && st_r.op == OP_TO &&
      !cmd_set[0] |=> !st_r.cmd[0] ##1 st_r.state != S_CHECK || st_r.op != OP_TO)
      else $error("copy-out bit not cleared");
   from_clear_a: assert property (st_r.state == S_FINISH && st_r.op == OP_FROM &&
      !cmd_set[1] |=> !st_r.cmd[1]) else $error("copy-in bit not cleared");
   cmp_clear_a: assert property (st_r.state == S_FINISH && st_r.op == OP_CMP &&
      !cmd_set[2] |=> !st_r.cmd[2]) else $error("compare bit not cleared");
   cmp_diff_a: assert property (st_r.state == S_CAS_REQ && st_r.op == OP_CMP &&
      ack_s && rdata_s != st_r.data |=> st_r.diff [*2]) else $error("difference lost");
   pgm_err_a: assert property (st_r.state == S_CHECK && st_r.op != OP_CMP &&
      prog_mode |=> st_r.err[CTC_E_PGM] && st_r.state == S_FINISH)
      else $error("program mode error missing");
   wp_err_a: assert property (st_r.state == S_CHECK && st_r.op == OP_TO &&
      !prog_mode && wp_flag |=> st_r.err == 4'h2 ##1 !st_r.cmd[0] || $past(cmd_set[0]))
      else $error("write protect error missing");
   cap_err_a: assert property (st_r.state == S_CHECK && st_r.op == OP_FROM &&
      !prog_mode && cas_len_s > UM_WORDS |=> st_r.err[CTC_E_CAP])
      else $error("capacity error missing");
   noprg_err_a: assert property (st_r.state == S_CHECK && st_r.op == OP_FROM &&
      !prog_mode && cas_len_s == '0 |=> st_r.err == 4'h8) else $error("no program error missing");
   eprom_wp_a: assert property (type_s == CTC_CT_EPROM && setup &&
      paddr == PAW'(CTC_ADDR_STAT) |=> prdata[CTC_SB_WP]) else $error("EPROM not protected");
   accept_clr_a: assert property (st_r.state == S_IDLE && |st_r.cmd |=>
      st_r.err == '0 && !st_r.diff && st_r.state == S_CHECK) else $error("flags not cleared");
endmodule

// [tb/ctc_cas_model.sv]
// Behavioural cassette: word store answering the four-phase request handshake
`timescale 1ns/10ps
module ctc_cas_model (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Answer delay in cycles
   input  wire logic [3:0]  dly,
   // Cassette pins
   input  wire logic [13:0] cas_addr,
   input  wire logic [15:0] cas_wdata,
   input  wire logic        cas_we,
   input  wire logic        cas_re,
   output logic             cas_ack,
   output logic [15:0]      cas_rdata
);
   logic [15:0] mem [16];
   logic [3:0]  cnt;
   // Ack after dly cycles, held until the request drops
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cas_ack <= 1'b0;
         cnt     <= 4'h0;
      end else if ((cas_we | cas_re) && !cas_ack) begin
         if (cnt >= dly) begin
            cas_ack <= 1'b1;
            cnt     <= 4'h0;
            if (cas_we) mem[cas_addr[3:0]] <= cas_wdata;
         end else begin
            cnt <= cnt + 4'h1;
         end
      end else if (!(cas_we | cas_re)) begin
         cas_ack <= 1'b0;
      end
   end
   // Data line shows garbage once ack is gone, so late sampling is caught
   assign cas_rdata = cas_ack ? mem[cas_addr[3:0]] : ~mem[cas_addr[3:0]];
endmodule

// [tb/ctc_top_tb.sv]
// Self-checking bench for the cassette transfer control block
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module ctc_top_tb;
   import ctc_pkg::*;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, prog_mode, busy;
   logic cas_wp_sw, cas_ack, um_we, cas_we, cas_re;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [14:0] prog_len, cas_len;
   logic [13:0] um_addr, cas_addr;
   logic [15:0] um_wdata, um_rdata, cas_rdata, cas_wdata, orig;
   logic [3:0]  cas_type, dly;
   logic [15:0] um [16];
   int checks, miscompares, cyc;
   logic [3:0] t;
   logic       ws;

   ctc_top dut (.clk(clk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .irq(irq), .prog_mode(prog_mode), .prog_len(prog_len),
      .um_addr(um_addr), .um_wdata(um_wdata), .um_we(um_we), .um_rdata(um_rdata),
      .cas_type(cas_type), .cas_wp_sw(cas_wp_sw), .cas_len(cas_len), .cas_ack(cas_ack),
      .cas_rdata(cas_rdata), .cas_addr(cas_addr), .cas_wdata(cas_wdata), .cas_we(cas_we),
      .cas_re(cas_re), .busy(busy));
   ctc_cas_model cas (.clk(clk), .rst(rst), .dly(dly), .cas_addr(cas_addr),
      .cas_wdata(cas_wdata), .cas_we(cas_we), .cas_re(cas_re), .cas_ack(cas_ack),
      .cas_rdata(cas_rdata));

   ////////////////////////////////////////////////////////////////////////////////
   // Program memory with one cycle read latency
   always @(posedge clk) begin
      um_rdata <= um[um_addr[3:0]];
      if (um_we) um[um_addr[3:0]] <= um_wdata;
   end
   // Clock and hang guard
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         wrap_up();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One APB transfer, then an idle edge so back-to-back calls never clash
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      ws = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // Issue a command, poll until the self-clearing bits drop, check the word
   task automatic cmd(input logic [15:0] c, input logic [31:0] exp);
      int n;
      apb(1'b1, 12'(CTC_ADDR_CMD), {16'h0000, c});
      n = 0;
      do begin
         apb(1'b0, 12'(CTC_ADDR_CMD), 32'h0000_0000);
         n++;
      end while (rd[2:0] !== 3'b000 && n < 200);
      `CHK(rd, exp)
      `CHK(busy, 1'b0)
   endtask
   task automatic wrap_up();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
      prog_mode = 1'b0; prog_len = '0; cas_type = CTC_CT_NONE; cas_wp_sw = 1'b0;
      cas_len = '0; dly = 4'h3;
      for (int i = 0; i < 16; i++) um[i] = 16'ha500 ^ 16'(i);
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      // Every type code, write protect only on switch or EPROM
      for (int i = 0; i < 5; i++) begin
         t = 4'(i);
         cas_type  <= t;
         cas_wp_sw <= t[0];
         repeat (4) @(posedge clk);
         apb(1'b0, 12'(CTC_ADDR_STAT), 32'h0000_0000);
         `CHK(rd, {24'h0, t, 1'b0, (t == 4) || (t != 0 && t[0]), 2'b00})
      end
      // Refusals, each clearing the previous flag
      prog_mode <= 1'b1;
      cmd(16'h0001, 32'h0000_1000);
      prog_mode <= 1'b0;
      cas_type  <= CTC_CT_EE4K;
      cas_wp_sw <= 1'b1;
      repeat (4) @(posedge clk);
      cmd(16'h0001, 32'h0000_2000);
      cas_wp_sw <= 1'b0;
      prog_len  <= 15'h1001;
      repeat (4) @(posedge clk);
      cmd(16'h0001, 32'h0000_4000);
      cmd(16'h0002, 32'h0000_8000);
      // Real copy out, slow cassette
      cas_type <= CTC_CT_FL16K;
      prog_len <= 15'h0004;
      cas_len  <= 15'h0004;
      repeat (4) @(posedge clk);
      cmd(16'h0001, 32'h0000_0000);
      for (int i = 0; i < 4; i++) `CHK(cas.mem[i], um[i])
      cmd(16'h0004, 32'h0000_0000);
      orig = um[2];
      um[2] = ~orig;
      cmd(16'h0004, 32'h0000_0008);
      // Copy back with a prompt cassette restores the word
      dly <= 4'h0;
      cmd(16'h0002, 32'h0000_0000);
      `CHK(um[2], orig)
      // Cassette program too long for memory, then a compare whose lengths differ
      cas_len <= 15'h4001;
      repeat (4) @(posedge clk);
      cmd(16'h0002, 32'h0000_4000);
      cmd(16'h0004, 32'h0000_0008);
      // Interrupt: both events seen, masked, enabled, cleared
      apb(1'b0, 12'(CTC_ADDR_IRQ_ST), 32'h0000_0000);
      `CHK(rd, 32'h0000_0003)
      `CHK(irq, 1'b0)
      apb(1'b1, 12'(CTC_ADDR_IRQ_EN), 32'h0000_0003);
      `CHK(irq, 1'b1)
      apb(1'b1, 12'(CTC_ADDR_IRQ_CLR), 32'h0000_0003);
      `CHK(irq, 1'b0)
      // Unmapped address answers with an error and zero data
      apb(1'b0, 12'h100, 32'h0000_0000);
      `CHK({ws, rd}, {1'b1, 32'h0000_0000})
      wrap_up();
   end
endmodule
